//--- core/link_sequencer.sv
// Link table sequencer with its AXI4-Lite register slave
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module link_sequencer (
	// Clock and reset
	input  wire logic                 CLOCK,
	input  wire logic                 RST_N,
	// Register bus
	input  wire seqp::axi_req_s       AXI_REQ,
	output seqp::axi_rsp_s            AXI_RSP,
	// Asynchronous trigger and gate pins
	input  wire logic                 TRIG_IN,
	input  wire logic                 GATE_IN,
	// Waveform player
	input  wire logic                 SEG_END,
	output logic [seqp::SEG_W-1:0]    SEG_INDEX,
	output logic                      SEG_PLAY,
	output logic                      SEQUENCE_SPAN_MARKER
);

	typedef struct packed {
		logic                         aw_got;
		logic                         w_got;
		logic [seqp::ADDR_W-1:0]      waddr;
		logic [31:0]                  wdata;
		logic [3:0]                   wstrb;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		seqp::run_e                   run;
		seqp::adv_e                   adv;
		logic                         seq_en;
		logic                         mark_src;
		logic [3:0]                   sel;
		logic                         err;
		seqp::link_s                  stage;
		logic [seqp::STEP_W:0]        apos;
		logic [seqp::TABLES-1:0][seqp::LINKS-1:0] valid;
		seqp::seq_e                   st;
		logic [seqp::STEP_W-1:0]      step;
		logic [seqp::LOOP_W-1:0]      cnt;
		logic                         tpend;
		logic [seqp::SEG_W-1:0]       seg;
		logic                         play;
		logic                         marker;
		logic [2:0]                   tsync;
		logic [1:0]                   gsync;
	} state_s;

	state_s                  s;
	state_s                  n;
	seqp::link_s             mem [seqp::TABLES*seqp::LINKS];
	seqp::link_s             cur;
	seqp::link_s             nxl;
	seqp::link_s             mem_wd;
	logic                    mem_we;
	logic [7:0]              mem_wa;
	logic                    trig;
	logic                    gate;
	logic                    seg_done;
	logic                    adv_now;
	logic                    wrap_ok;
	logic                    start;
	logic [seqp::STEP_W:0]   first;
	logic [seqp::STEP_W:0]   nxt;
	logic [seqp::LINKS-1:0]  vt;
	logic                    wr_go;
	logic                    wr_ok;
	logic [31:0]             wd;
	logic [31:0]             rd;
	logic [1:0]              rresp;
	seqp::run_e              nrun;
	seqp::adv_e              nadv;
	logic                    clash;
	seqp::op_e               op;
	logic [seqp::STEP_W-1:0] cstep;
	logic [3:0]              nsel;

	// Highest valid link below a bound, found flag on top
	function automatic logic [seqp::STEP_W:0] below(
		input logic [seqp::LINKS-1:0] v,
		input int                     bound
	);
		logic [seqp::STEP_W:0] r;
		r = '0;
		for (int i = 0; i < seqp::LINKS; i++) begin
			if (v[i] && i < bound) begin
				r = {1'b1, i[seqp::STEP_W-1:0]};
			end
		end
		return r;
	endfunction

	// Flat link memory address of a table and step
	function automatic logic [7:0] maddr(
		input logic [3:0]              t,
		input logic [seqp::STEP_W-1:0] k
	);
		return 8'(int'(t) * seqp::LINKS + int'(k));
	endfunction

	// Bus handshakes straight from state
	assign AXI_RSP.awready = !s.aw_got && !s.bvalid;
	assign AXI_RSP.wready  = !s.w_got && !s.bvalid;
	assign AXI_RSP.bvalid  = s.bvalid;
	assign AXI_RSP.bresp   = s.bresp;
	assign AXI_RSP.arready = !s.rvalid;
	assign AXI_RSP.rvalid  = s.rvalid;
	assign AXI_RSP.rdata   = s.rdata;
	assign AXI_RSP.rresp   = s.rresp;

	// Player outputs are registered
	assign SEG_INDEX            = s.seg;
	assign SEG_PLAY             = s.play;
	assign SEQUENCE_SPAN_MARKER = s.marker;

	// Next state of bus slave, registers and sequencer
	always_comb begin
		n      = s;
		mem_we = 1'b0;
		mem_wa = maddr(s.sel, s.step);
		mem_wd = s.stage;
		wd     = s.wdata;
		wr_go  = s.aw_got && s.w_got && !s.bvalid;
		wr_ok  = s.wstrb == seqp::STRB_FULL;
		nrun   = seqp::run_e'(wd[seqp::CTRL_RUN +: 2]);
		nadv   = seqp::adv_e'(wd[seqp::CTRL_ADV +: 2]);
		nsel   = wd[seqp::CTRL_SEL +: 4];
		op     = seqp::op_e'(wd[seqp::CMD_OP +: 3]);
		cstep  = wd[seqp::CMD_STEP +: seqp::STEP_W];
		// Mode pairs that may not stand together, and the unused run code
		clash  = (nadv == seqp::ADV_TRIG && nrun != seqp::RUN_TRIG)
			|| ((nadv == seqp::ADV_STEP || nadv == seqp::ADV_MIX)
			&& nrun != seqp::RUN_CONT)
			|| wd[seqp::CTRL_RUN +: 2] == seqp::RUN_BAD;

		// Address and data may arrive in either order
		if (AXI_REQ.awvalid && !s.aw_got && !s.bvalid) begin
			n.aw_got = 1'b1;
			n.waddr  = AXI_REQ.awaddr;
		end
		if (AXI_REQ.wvalid && !s.w_got && !s.bvalid) begin
			n.w_got = 1'b1;
			n.wdata = AXI_REQ.wdata;
			n.wstrb = AXI_REQ.wstrb;
		end
		if (s.bvalid && AXI_REQ.bready) begin
			n.bvalid = 1'b0;
		end

		// Register write; partial strobes are refused whole
		if (wr_go) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = seqp::RESP_OKAY;
			if (!wr_ok) begin
				n.bresp = seqp::RESP_SLVERR;
			end else begin
				case (s.waddr)
					seqp::OFS_CTRL: begin
						// Output enable is its own bit, never set by a select
						n.seq_en   = wd[seqp::CTRL_SEQ];
						n.mark_src = wd[seqp::CTRL_MRK];
						if (nsel != 4'h0 && nsel <= seqp::SEL_LAST) begin
							n.sel = nsel - 4'h1;
						end
						if (!clash) begin
							n.run = nrun;
							n.adv = nadv;
						end
					end
					seqp::OFS_STATUS: begin
						if (wd[seqp::STAT_ERR]) begin
							n.err = 1'b0;
						end
					end
					seqp::OFS_LINK: begin
						n.stage = seqp::link_s'(wd[seqp::LINK_W-1:0]);
					end
					seqp::OFS_CMD: begin
						case (op)
							seqp::OP_DEFINE: begin
								mem_we = 1'b1;
								mem_wa = maddr(s.sel, cstep);
								n.valid[s.sel][cstep] = 1'b1;
							end
							seqp::OP_DELETE: begin
								n.valid[s.sel][cstep] = 1'b0;
							end
							seqp::OP_ERASE: begin
								n.valid[s.sel] = '0;
							end
							seqp::OP_ARRAY: begin
								n.valid[s.sel] = '0;
								n.apos         = '0;
							end
							default: begin
							end
						endcase
					end
					seqp::OFS_ARRAY: begin
						// Array words fill steps upward; extra words are dropped
						if (!s.apos[seqp::STEP_W]) begin
							mem_we = 1'b1;
							mem_wa = maddr(s.sel, s.apos[seqp::STEP_W-1:0]);
							mem_wd = seqp::link_s'(wd[seqp::LINK_W-1:0]);
							n.valid[s.sel][s.apos[seqp::STEP_W-1:0]] = 1'b1;
							n.apos = s.apos + 5'h01;
						end
					end
					default: begin
						n.bresp = seqp::RESP_SLVERR;
					end
				endcase
			end
		end
		// Conflict sets after any clear, so a set is never lost
		if (wr_go && wr_ok && s.waddr == seqp::OFS_CTRL && clash) begin
			n.err = 1'b1;
		end

		// Register read, answered one cycle after the address
		rd    = '0;
		rresp = seqp::RESP_OKAY;
		case (AXI_REQ.araddr)
			seqp::OFS_CTRL: begin
				rd = (32'(s.run) << seqp::CTRL_RUN)
					| (32'(s.adv) << seqp::CTRL_ADV)
					| (32'(s.seq_en) << seqp::CTRL_SEQ)
					| (32'(s.mark_src) << seqp::CTRL_MRK)
					| (32'(s.sel + 4'h1) << seqp::CTRL_SEL);
			end
			seqp::OFS_STATUS: begin
				rd = (32'(s.st != seqp::SQ_IDLE) << seqp::STAT_RUN)
					| (32'(s.err) << seqp::STAT_ERR)
					| (32'(s.st == seqp::SQ_WAIT) << seqp::STAT_WAIT)
					| (32'(s.step) << seqp::STAT_STEP);
			end
			seqp::OFS_LINK: begin
				rd = 32'(s.stage);
			end
			seqp::OFS_CMD, seqp::OFS_ARRAY: begin
				rd = '0;
			end
			default: begin
				rresp = seqp::RESP_SLVERR;
			end
		endcase
		if (s.rvalid && AXI_REQ.rready) begin
			n.rvalid = 1'b0;
		end
		if (AXI_REQ.arvalid && !s.rvalid) begin
			n.rvalid = 1'b1;
			n.rdata  = rd;
			n.rresp  = rresp;
		end

		// Trigger edge taken after two stages; first stage feeds only second
		n.tsync = {s.tsync[1:0], TRIG_IN};
		n.gsync = {s.gsync[0], GATE_IN};
		trig    = s.tsync[1] && !s.tsync[2];
		gate    = s.gsync[1];

		// Current link and its neighbours in the active table
		vt       = s.valid[s.sel];
		cur      = mem[maddr(s.sel, s.step)];
		first    = below(vt, seqp::LINKS);
		nxt      = below(vt, int'(s.step));
		// Zero repeats counts as one pass
		seg_done = ({1'b0, s.cnt} + 22'h000001) >= {1'b0, cur.loops};
		case (s.adv)
			seqp::ADV_STEP: begin
				adv_now = s.tpend || trig;
			end
			seqp::ADV_MIX: begin
				adv_now = cur.adv ? (s.tpend || trig) : seg_done;
			end
			default: begin
				adv_now = seg_done;
			end
		endcase
		// Table end wraps only while running on, else the output stops
		wrap_ok = s.run == seqp::RUN_CONT
			|| (s.run == seqp::RUN_GATED && gate);
		start   = s.run == seqp::RUN_CONT
			|| (s.run == seqp::RUN_TRIG && trig)
			|| (s.run == seqp::RUN_GATED && gate);

		// Sequencer walk
		case (s.st)
			seqp::SQ_IDLE: begin
				n.play  = 1'b0;
				n.tpend = 1'b0;
				if (s.seq_en && first[seqp::STEP_W] && start) begin
					n.st   = seqp::SQ_PLAY;
					n.step = first[seqp::STEP_W-1:0];
					n.cnt  = '0;
					n.play = 1'b1;
				end
			end
			seqp::SQ_PLAY: begin
				if (trig) begin
					n.tpend = 1'b1;
				end
				if (!s.seq_en || !vt[s.step]) begin
					n.st   = seqp::SQ_IDLE;
					n.play = 1'b0;
				end else if (SEG_END) begin
					if (!adv_now) begin
						n.cnt = s.cnt + 21'h000001;
					end else begin
						n.cnt   = '0;
						n.tpend = 1'b0;
						if (nxt[seqp::STEP_W]) begin
							n.step = nxt[seqp::STEP_W-1:0];
							if (s.adv == seqp::ADV_TRIG) begin
								n.st   = seqp::SQ_WAIT;
								n.play = 1'b0;
							end
						end else if (wrap_ok) begin
							n.step = first[seqp::STEP_W-1:0];
						end else begin
							n.st   = seqp::SQ_IDLE;
							n.play = 1'b0;
						end
					end
				end
			end
			seqp::SQ_WAIT: begin
				if (!s.seq_en || !vt[s.step]) begin
					n.st = seqp::SQ_IDLE;
				end else if (trig) begin
					n.st   = seqp::SQ_PLAY;
					n.play = 1'b1;
				end
			end
			default: begin
				n.st   = seqp::SQ_IDLE;
				n.play = 1'b0;
			end
		endcase

		// New segment loads at the old one's last sample, so no gap
		nxl = mem[maddr(s.sel, n.step)];
		if (n.st == seqp::SQ_PLAY) begin
			n.seg = nxl.seg;
		end
		n.marker = s.mark_src ? (n.st == seqp::SQ_PLAY && nxl.mark)
			: (n.st != seqp::SQ_IDLE);
	end

	// Link memory; contents need no reset, valid bits guard them
	always_ff @(posedge CLOCK) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// All control state
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			s <= {$bits(state_s){seqp::STATE_RESET}};
		end else begin
			s <= n;
		end
	end

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	// Last link of a table pass ends with no lower link to step to
	sequence last_link_done;
		s.st == seqp::SQ_PLAY && s.seq_en && vt[s.step] && SEG_END
			&& adv_now && !nxt[seqp::STEP_W];
	endsequence

	sequence ctrl_write;
		wr_go && wr_ok && s.waddr == seqp::OFS_CTRL;
	endsequence

	chk_conflict_flag:
		assert property (ctrl_write ##0 (nadv == seqp::ADV_TRIG
			&& nrun == seqp::RUN_CONT) |=> s.err
			&& s.adv == $past(s.adv))
		else $error("mode conflict not flagged");

	chk_trig_legal:
		assert property (s.adv == seqp::ADV_TRIG |-> s.run == seqp::RUN_TRIG)
		else $error("triggered advance outside triggered run");

	chk_step_legal:
		assert property ((s.adv == seqp::ADV_STEP || s.adv == seqp::ADV_MIX)
			|-> s.run == seqp::RUN_CONT)
		else $error("stepped or mixed advance outside continuous run");

	chk_end_stop:
		assert property (last_link_done ##0 s.run == seqp::RUN_TRIG
			|=> !SEG_PLAY && s.st == seqp::SQ_IDLE)
		else $error("triggered run did not stop at table end");

	chk_cont_wrap:
		assert property (last_link_done ##0 s.run == seqp::RUN_CONT
			|=> SEG_PLAY && s.step == $past(first[seqp::STEP_W-1:0]))
		else $error("continuous run did not restart table");

	chk_wait_hold:
		assert property (s.st == seqp::SQ_WAIT && !trig
			|=> !SEG_PLAY && $stable(SEG_INDEX))
		else $error("output moved while waiting for trigger");

	chk_step_hold:
		assert property (s.st == seqp::SQ_PLAY && s.adv == seqp::ADV_STEP
			&& !s.tpend && !trig |=> s.step == $past(s.step))
		else $error("stepped advance moved without trigger");

	chk_trig_pulse:
		assert property (trig |=> !trig)
		else $error("trigger pulse longer than one cycle");

	chk_erase_all:
		assert property (wr_go && wr_ok && s.waddr == seqp::OFS_CMD
			&& op == seqp::OP_ERASE |=> s.valid[$past(s.sel)] == '0)
		else $error("table not erased");

endmodule

//--- core/seqp.sv
// Constants and carrier types of the waveform link sequencer
package seqp;

	// Table geometry and field widths
	localparam int TABLES = 10;
	localparam int LINKS  = 16;
	localparam int STEP_W = 4;
	localparam int SEG_W  = 8;
	localparam int LOOP_W = 21;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LINK   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ARRAY  = 8'h10;

	// Control word fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_ADV = 2;
	localparam int CTRL_SEQ = 4;
	localparam int CTRL_MRK = 5;
	localparam int CTRL_SEL = 8;

	// Status word fields
	localparam int STAT_RUN  = 0;
	localparam int STAT_ERR  = 1;
	localparam int STAT_WAIT = 2;
	localparam int STAT_STEP = 8;

	// Command word fields
	localparam int CMD_STEP = 0;
	localparam int CMD_OP   = 8;

	// Bus answers, full strobe, control field limits and reset of all control state
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] STRB_FULL   = 4'hF;
	localparam logic [1:0] RUN_BAD     = 2'h3;
	localparam logic [3:0] SEL_LAST    = 4'hA;
	localparam logic       STATE_RESET = 1'b0;

	typedef enum logic [1:0] {RUN_CONT, RUN_TRIG, RUN_GATED} run_e;
	typedef enum logic [1:0] {ADV_AUTO, ADV_TRIG, ADV_STEP, ADV_MIX} adv_e;
	typedef enum logic [2:0] {
		OP_NONE, OP_DEFINE, OP_DELETE, OP_ERASE, OP_ARRAY
	} op_e;
	typedef enum logic [1:0] {SQ_IDLE, SQ_PLAY, SQ_WAIT} seq_e;

	// One link entry, also the link word layout from bit 0
	typedef struct packed {
		logic              mark;
		logic              adv;
		logic [SEG_W-1:0]  seg;
		logic [LOOP_W-1:0] loops;
	} link_s;
	localparam int LINK_W = $bits(link_s);

	// AXI4-Lite master to slave
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axi_req_s;

	// AXI4-Lite slave to master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_s;

endpackage

//--- verif/seg_player.sv
// Waveform player stand-in that ends each segment pass after a fixed length
`timescale 1ns/1ps
module seg_player #(
	parameter int PASS_LEN = 8
) (
	// Clock and reset
	input  wire logic CLOCK,
	input  wire logic RST_N,
	// Sequencer side
	input  wire logic SEG_PLAY,
	output logic      SEG_END
);
	int cnt;

	// Pass timer; restarts at once so passes abut with no gap
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			cnt <= 0;
			SEG_END <= 1'b0;
		end else if (SEG_PLAY) begin
			SEG_END <= (cnt == PASS_LEN - 2);
			cnt <= (cnt == PASS_LEN - 1) ? 0 : cnt + 1;
		end else begin
			// Holding: the last sample stays, no pass ends
			cnt <= 0;
			SEG_END <= 1'b0;
		end
	end
endmodule

//--- verif/tb.sv
// Register-level testbench of the link sequencer
`timescale 1ns/1ps
module tb;
	logic           CLOCK = 1'b0;
	logic           RST_N = 1'b0;
	seqp::axi_req_s req = '0;
	seqp::axi_rsp_s rsp;
	logic           trig = 1'b0;
	logic           gate = 1'b0;
	logic           seg_end;
	logic [7:0]     seg_idx;
	logic           seg_play;
	logic           marker;
	int             fails = 0;
	int             n_checks = 0;
	logic [31:0]    rd;
	logic [1:0]     rs;

	// 100 MHz clock
	always #5 CLOCK = ~CLOCK;

	link_sequencer i_dut (
		.CLOCK               (CLOCK),
		.RST_N               (RST_N),
		.AXI_REQ             (req),
		.AXI_RSP             (rsp),
		.TRIG_IN             (trig),
		.GATE_IN             (gate),
		.SEG_END             (seg_end),
		.SEG_INDEX           (seg_idx),
		.SEG_PLAY            (seg_play),
		.SEQUENCE_SPAN_MARKER(marker)
	);

	seg_player #(.PASS_LEN(8)) i_ply (
		.CLOCK   (CLOCK),
		.RST_N   (RST_N),
		.SEG_PLAY(seg_play),
		.SEG_END (seg_end)
	);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	// A wait that ran out ends the run
	task automatic hang();
		fails++;
		$display("CHECK FAILED %0t wait ran out", $time);
		wrap_up();
	endtask

	// Bus write; address and data offered together, held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s = seqp::STRB_FULL);
		logic aw;
		logic w;
		int   i;
		@(posedge CLOCK);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= s;
		req.bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge CLOCK);
			if (!aw && !w && rsp.bvalid) begin
				rs = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
			if (aw && rsp.awready) begin
				aw = 1'b0;
				req.awvalid <= 1'b0;
			end
			if (w && rsp.wready) begin
				w = 1'b0;
				req.wvalid <= 1'b0;
			end
		end
		if (i == 50)
			hang();
		#1;
	endtask

	// Bus read; data and response taken at the rvalid edge
	task automatic rdr(input logic [7:0] a);
		logic ar;
		int   i;
		@(posedge CLOCK);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		ar = 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge CLOCK);
			if (!ar && rsp.rvalid) begin
				rd = rsp.rdata;
				rs = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
			if (ar && rsp.arready) begin
				ar = 1'b0;
				req.arvalid <= 1'b0;
			end
		end
		if (i == 50)
			hang();
		#1;
	endtask

	// Count ended segment passes, bounded
	task automatic passes(input int n);
		int i;
		int k;
		k = 0;
		for (i = 0; i < 400 && k < n; i++) begin
			@(posedge CLOCK);
			if (seg_end === 1'b1)
				k++;
		end
		if (k < n)
			hang();
		#1;
	endtask

	// Trigger pin pulse, long enough for the synchroniser
	task automatic fire();
		@(posedge CLOCK);
		trig <= 1'b1;
		repeat (2) @(posedge CLOCK);
		trig <= 1'b0;
	endtask

	function automatic logic [31:0] lw(input logic [7:0] sg,
			input logic [20:0] lp);
		lw = {3'b000, sg, lp};
	endfunction

	// Main sequence
	initial begin
		int i;
		repeat (10) @(posedge CLOCK);
		RST_N <= 1'b1;
		rdr(seqp::OFS_CTRL);
		chk(rd, 32'h0000_0100, "ctrl reset");
		for (int t = 1; t <= 10; t++) begin
			wr(seqp::OFS_CTRL, 32'(t) << 8);
			rdr(seqp::OFS_CTRL);
			chk(rd & 32'h0000_0F00, 32'(t) << 8, "table");
			chk(32'(seg_play), 32'h0, "no auto play");
		end
		wr(seqp::OFS_CTRL, 32'h0000_0000);
		rdr(seqp::OFS_CTRL);
		chk(rd, 32'h0000_0A00, "table 0 ignored");
		$display("test select done");
		// Unmapped place and partial strobe are refused
		rdr(8'h40);
		chk({30'h0, rs}, {30'h0, seqp::RESP_SLVERR}, "unmapped");
		chk(rd, 32'h0, "unmapped data");
		wr(seqp::OFS_CTRL, 32'h0000_0110, 4'h3);
		chk({30'h0, rs}, {30'h0, seqp::RESP_SLVERR}, "strobe");
		// Refused write must leave the earlier control word intact
		rdr(seqp::OFS_CTRL);
		chk(rd, 32'h0000_0A00, "ctrl kept");
		$display("test bus errors done");
		// Mode conflicts leave the run and advance fields as they were
		wr(seqp::OFS_CTRL, 32'h0000_0104);
		rdr(seqp::OFS_STATUS);
		chk(rd & 32'h2, 32'h2, "trig adv in cont");
		rdr(seqp::OFS_CTRL);
		chk(rd & 32'hF, 32'h0, "mode kept");
		wr(seqp::OFS_STATUS, 32'h2);
		rdr(seqp::OFS_STATUS);
		chk(rd & 32'h2, 32'h0, "conflict cleared");
		wr(seqp::OFS_CTRL, 32'h0000_0109);
		rdr(seqp::OFS_STATUS);
		chk(rd & 32'h2, 32'h2, "step adv in trig");
		rdr(seqp::OFS_CTRL);
		chk(rd & 32'hF, 32'h0, "mode kept");
		wr(seqp::OFS_STATUS, 32'h2);
		wr(seqp::OFS_CTRL, 32'h0000_0100);
		$display("test conflict done");
		// Steps 3 and 1, continuous run, automatic advance
		wr(seqp::OFS_LINK, lw(8'h11, 21'h2));
		wr(seqp::OFS_CMD, 32'h0000_0103);
		wr(seqp::OFS_LINK, lw(8'h22, 21'h1));
		wr(seqp::OFS_CMD, 32'h0000_0101);
		wr(seqp::OFS_CTRL, 32'h0000_0110);
		chk(32'(seg_idx), 32'h11, "highest step first");
		chk(32'(marker), 32'h1, "marker high");
		passes(1);
		chk(32'(seg_idx), 32'h11, "second repeat");
		passes(1);
		chk(32'(seg_idx), 32'h22, "next link");
		chk(32'(seg_play), 32'h1, "no gap");
		passes(1);
		chk(32'(seg_idx), 32'h11, "wrap");
		wr(seqp::OFS_CTRL, 32'h0000_0100);
		chk(32'(marker), 32'h0, "marker low");
		$display("test auto done");
		// Delete step 3, leaving one link
		wr(seqp::OFS_CMD, 32'h0000_0203);
		wr(seqp::OFS_CTRL, 32'h0000_0110);
		chk(32'(seg_idx), 32'h22, "deleted link gone");
		passes(3);
		chk(32'(seg_idx), 32'h22, "single link");
		chk(32'(seg_play), 32'h1, "single link runs");
		// Erase the table
		wr(seqp::OFS_CTRL, 32'h0000_0100);
		wr(seqp::OFS_CMD, 32'h0000_0300);
		wr(seqp::OFS_CTRL, 32'h0000_0110);
		rdr(seqp::OFS_STATUS);
		chk(rd & 32'h1, 32'h0, "empty table idle");
		chk(32'(seg_play), 32'h0, "empty table silent");
		wr(seqp::OFS_CTRL, 32'h0000_0100);
		$display("test delete done");
		// Array load, stepped advance; repeat counts of 5 are ignored
		wr(seqp::OFS_CMD, 32'h0000_0400);
		wr(seqp::OFS_ARRAY, lw(8'h33, 21'h5));
		wr(seqp::OFS_ARRAY, lw(8'h44, 21'h5));
		wr(seqp::OFS_CTRL, 32'h0000_0118);
		chk(32'(seg_idx), 32'h44, "array step 1");
		passes(7);
		chk(32'(seg_idx), 32'h44, "repeats ignored");
		fire();
		passes(2);
		chk(32'(seg_idx), 32'h33, "trigger steps");
		rdr(seqp::OFS_STATUS);
		chk(rd & 32'h0000_0F00, 32'h0, "step field");
		wr(seqp::OFS_CTRL, 32'h0000_0100);
		$display("test stepped done");
		// One link, triggered run and advance: a burst of three
		wr(seqp::OFS_CMD, 32'h0000_0300);
		wr(seqp::OFS_LINK, lw(8'h55, 21'h3));
		wr(seqp::OFS_CMD, 32'h0000_0102);
		wr(seqp::OFS_CTRL, 32'h0000_0115);
		chk(32'(seg_play), 32'h0, "waits for trigger");
		fire();
		for (i = 0; i < 20 && seg_play !== 1'b1; i++)
			@(posedge CLOCK);
		chk(32'(seg_play), 32'h1, "burst starts");
		passes(2);
		chk(32'(seg_play), 32'h1, "repeats play");
		passes(1);
		chk(32'(seg_play), 32'h0, "burst stops");
		chk(32'(seg_idx), 32'h55, "holds last");
		$display("test burst done");
		// Second link, marked and flagged; waits for a trigger between links
		wr(seqp::OFS_LINK, 32'h6000_0000 | lw(8'h66, 21'h1));
		wr(seqp::OFS_CMD, 32'h0000_0101);
		fire();
		for (i = 0; i < 20 && seg_play !== 1'b1; i++)
			@(posedge CLOCK);
		chk(32'(seg_play), 32'h1, "trigger starts");
		passes(3);
		chk(32'(seg_play), 32'h0, "idle between links");
		chk(32'(seg_idx), 32'h55, "last segment held");
		chk(32'(marker), 32'h1, "marker spans wait");
		rdr(seqp::OFS_STATUS);
		chk(rd & 32'h0000_0F07, 32'h0000_0105, "wait on step 1");
		fire();
		for (i = 0; i < 20 && seg_play !== 1'b1; i++)
			@(posedge CLOCK);
		chk(32'(seg_idx), 32'h66, "trigger advances");
		passes(1);
		chk(32'(seg_play), 32'h0, "run stops at end");
		$display("test trig advance done");
		// Mixed advance with marker bit mode, continuous run
		wr(seqp::OFS_CTRL, 32'h0000_013C);
		chk(32'(seg_idx), 32'h55, "mixed start");
		chk(32'(marker), 32'h0, "unmarked link");
		passes(3);
		chk(32'(seg_idx), 32'h66, "flag 0 advances");
		chk(32'(marker), 32'h1, "marked link");
		passes(3);
		chk(32'(seg_idx), 32'h66, "flag 1 repeats");
		fire();
		passes(2);
		chk(32'(seg_idx), 32'h55, "trigger moves on");
		wr(seqp::OFS_CTRL, 32'h0000_0100);
		$display("test mixed done");
		// Gated run; a closed gate lets the pass finish first
		wr(seqp::OFS_CTRL, 32'h0000_0112);
		chk(32'(seg_play), 32'h0, "gate closed");
		@(posedge CLOCK);
		gate <= 1'b1;
		passes(1);
		@(posedge CLOCK);
		gate <= 1'b0;
		passes(2);
		chk(32'(seg_idx), 32'h66, "pass goes on");
		chk(32'(seg_play), 32'h1, "still playing");
		passes(1);
		chk(32'(seg_play), 32'h0, "stops at end");
		$display("test gated done");
		wrap_up();
	end
endmodule
